// File: hdl/mds_core.sv
// data space, alu flags, status and interrupt logic of the core
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Function
// - table address is pc bits 11..8 plus pointer; last page uses 1011
// - unimplemented special addresses below 60H read as 00H
// - general storage at 60H..FFH is readable and writable
// - addresses 00H and 02H redirect through pointer zero and one
// - pointer aimed at 00H or 02H reads 00H, write does nothing
// - each pointer is 8 bits and reaches any data location
// - single bit set and clear work on data bits except dedicated ones
// - 8-bit alu with arithmetic, logic, rotate, inc, dec and skip tests
// - bit 0 carry: carry out of add or no borrow of subtract
// - bit 1 half carry from the low nibble
// - bit 2 zero flag set when result is zero
// - bit 3 overflow: carry into msb differs from carry out
// - bit 4 power-down cleared by reset or watchdog clear, set by halt
// - bit 5 time-out cleared by reset, clear or halt, set on time-out
// - software writes keep bits 4 and 5; bits 6 and 7 read zero
// - only the program counter is saved on interrupt entry
// - servicing clears global enable; new requests only set flags
// - no interrupt is taken while the return stack is full
// - timer overflow sets bit 5; service calls 08H, clears flag and enable
// - pin event sets bit 4; service calls 04H, clears flag and enable
// - edge select high gives rising edge, low gives falling edge
// - irq bits 0..2 are global, external, timer enables; bit 3 reads 0
// - return from interrupt sets global enable; plain return does not
// - external request wins over timer when both are pending
// - timer flag at bit 5 stays until serviced or cleared; 6,7 read 0
////////////////////////////////////////////////////////////////////////
module mds_core
    import mds_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic        rd_en_in,
    input  wire logic        wr_en_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        bit_set_in,
    input  wire logic        bit_clr_in,
    input  wire logic [2:0]  bit_sel_in,
    input  wire logic        alu_en_in,
    input  wire logic [3:0]  alu_op_in,
    input  wire logic [7:0]  alu_operand_in,
    input  wire logic        alu_to_acc_in,
    input  wire logic        tbl_rd_in,
    input  wire logic        tbl_last_in,
    input  wire logic [11:0] pc_in,
    input  wire logic        tbl_high_we_in,
    input  wire logic [7:0]  tbl_high_in,
    input  wire logic        halt_in,
    input  wire logic        wdt_clear_in,
    input  wire logic        wdt_timeout_in,
    input  wire logic        timer_ovf_in,
    input  wire logic        ext_irq_pin_in,
    input  wire logic        edge_select_output_in,
    input  wire logic        stack_full_in,
    input  wire logic        irq_slot_in,
    input  wire logic        ret_irq_in,
    output logic      [7:0]  rd_data_out,
    output logic             rd_valid_out,
    output logic      [11:0] tbl_addr_out,
    output logic             irq_call_out,
    output logic      [11:0] irq_vector_out,
    output logic             pcl_load_out,
    output logic      [7:0]  pcl_data_out,
    output logic             skip_out
);

    typedef struct packed {
        logic [7:0]  pointer_zero;
        logic [7:0]  pointer_one;
        logic [7:0]  accumulator;
        logic [7:0]  table_pointer;
        logic [7:0]  table_high_byte;
        logic        carry_flag, half_carry_flag, zero_flag, overflow_flag;
        logic        powerdown_flag, watchdog_timeout_flag;
        logic        global_irq_enable, ext_irq_enable, timer_irq_enable;
        logic        ext_irq_flag, timer_request_flag;
        logic        pin_s1, pin_s2, pin_prev;
        logic [7:0]  rd_data;
        logic        rd_valid;
        logic [11:0] tbl_addr;
        logic        irq_call;
        logic [11:0] irq_vec;
        logic        pcl_load;
        logic [7:0]  pcl_data;
        logic        skip;
    } mds_state_s;

    mds_state_s st, next_st;
    logic [7:0] ram [MDS_RAM_FIRST:MDS_RAM_LAST];
    logic [7:0] ea, cur, wd, res, bb;
    logic       we, mem_we, ind_self, cin;
    logic       ext_edge, take_ext, take_tmr;
    logic [4:0] lo;
    logic [7:0] s7;
    logic [8:0] s8, d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.rd_valid = rd_en_in;
        next_st.irq_call = 1'b0;
        next_st.pcl_load = 1'b0;
        next_st.skip = 1'b0;
        // indirect slots redirect through the pointers
        ea = addr_in;
        if (addr_in == MDS_ADR_IND0) begin
            ea = st.pointer_zero;
        end else if (addr_in == MDS_ADR_IND1) begin
            ea = st.pointer_one;
        end
        ind_self = (ea == MDS_ADR_IND0) || (ea == MDS_ADR_IND1);
        case (ea)
            MDS_ADR_PTR0:  cur = st.pointer_zero;
            MDS_ADR_PTR1:  cur = st.pointer_one;
            MDS_ADR_ACC:   cur = st.accumulator;
            MDS_ADR_PCL:   cur = pc_in[7:0];
            MDS_ADR_TABLE_POINTER:  cur = st.table_pointer;
            MDS_ADR_TABLE_HIGH_BYTE:  cur = st.table_high_byte;
            MDS_ADR_FLAGS: cur = {2'b00, st.watchdog_timeout_flag,
                                  st.powerdown_flag, st.overflow_flag,
                                  st.zero_flag, st.half_carry_flag,
                                  st.carry_flag};
            MDS_ADR_IRQC:  cur = {2'b00, st.timer_request_flag,
                                  st.ext_irq_flag, 1'b0,
                                  st.timer_irq_enable, st.ext_irq_enable,
                                  st.global_irq_enable};
            default: begin
                // reserved space below general storage reads zero
                if (ea >= MDS_RAM_LO) begin
                    cur = ram[ea];
                end else begin
                    cur = MDS_READ_ZERO;
                end
            end
        endcase
        if (ind_self) cur = MDS_READ_ZERO;
        if (rd_en_in) next_st.rd_data = cur;
        // write source: plain write, bit edit or alu result
        wd = wdata_in;
        we = wr_en_in;
        if (bit_set_in || bit_clr_in) begin
            wd = cur;
            wd[bit_sel_in] = bit_set_in;
            we = 1'b1;
        end
        // alu: accumulator is first operand, unary ops other than decimal adjust use the operand
        bb = alu_operand_in;
        cin = 1'b0;
        case (alu_op_in)
            MDS_OP_ADC: cin = st.carry_flag;
            MDS_OP_SUB: begin
                bb = ~alu_operand_in;
                cin = 1'b1;
            end
            MDS_OP_SBC: begin
                bb = ~alu_operand_in;
                cin = st.carry_flag;
            end
            default: cin = 1'b0;
        endcase
        lo = {1'b0, st.accumulator[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        s7 = {1'b0, st.accumulator[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
        s8 = {1'b0, st.accumulator} + {1'b0, bb} + {8'h00, cin};
        d = {1'b0, st.accumulator};
        if (st.accumulator[3:0] > MDS_BCD_MAX || st.half_carry_flag)
            d = d + MDS_ADJ_LO;
        if (d[7:4] > MDS_BCD_MAX || st.carry_flag || d[8])
            d = d + MDS_ADJ_HI;
        res = s8[7:0];
        if (alu_en_in) begin
            case (alu_op_in)
                MDS_OP_ADD, MDS_OP_ADC, MDS_OP_SUB, MDS_OP_SBC: begin
                    next_st.carry_flag = s8[8];
                    next_st.half_carry_flag = lo[4];
                    next_st.overflow_flag = s7[7] ^ s8[8];
                end
                MDS_OP_DAA: begin
                    res = d[7:0];
                    next_st.carry_flag = d[8] | st.carry_flag;
                end
                MDS_OP_AND: res = st.accumulator & alu_operand_in;
                MDS_OP_OR:  res = st.accumulator | alu_operand_in;
                MDS_OP_XOR: res = st.accumulator ^ alu_operand_in;
                MDS_OP_CPL: res = ~alu_operand_in;
                MDS_OP_RL:  res = {alu_operand_in[6:0], alu_operand_in[7]};
                MDS_OP_RR:  res = {alu_operand_in[0], alu_operand_in[7:1]};
                MDS_OP_RLC: begin
                    res = {alu_operand_in[6:0], st.carry_flag};
                    next_st.carry_flag = alu_operand_in[7];
                end
                MDS_OP_RRC: begin
                    res = {st.carry_flag, alu_operand_in[7:1]};
                    next_st.carry_flag = alu_operand_in[0];
                end
                MDS_OP_INC: res = alu_operand_in + 8'h01;
                MDS_OP_DEC: res = alu_operand_in - 8'h01;
                default:    res = alu_operand_in;
            endcase
            // rotates and decimal adjust leave zero alone
            if (!(alu_op_in inside {MDS_OP_DAA, MDS_OP_RL, MDS_OP_RR,
                                    MDS_OP_RLC, MDS_OP_RRC})) begin
                next_st.zero_flag = (res == MDS_READ_ZERO);
            end
            next_st.skip = (res == MDS_READ_ZERO);
            if (alu_to_acc_in) begin
                next_st.accumulator = res;
            end else begin
                wd = res;
                we = 1'b1;
            end
        end
        // write decode; indirect self-target is dropped
        mem_we = 1'b0;
        if (we && !ind_self) begin
            case (ea)
                MDS_ADR_PTR0:  next_st.pointer_zero = wd;
                MDS_ADR_PTR1:  next_st.pointer_one = wd;
                MDS_ADR_ACC:   next_st.accumulator = wd;
                MDS_ADR_PCL: begin
                    next_st.pcl_load = 1'b1;
                    next_st.pcl_data = wd;
                end
                MDS_ADR_TABLE_POINTER:  next_st.table_pointer = wd;
                MDS_ADR_FLAGS: begin
                    next_st.carry_flag = wd[MDS_F_C];
                    next_st.half_carry_flag = wd[MDS_F_AC];
                    next_st.zero_flag = wd[MDS_F_Z];
                    next_st.overflow_flag = wd[MDS_F_OV];
                end
                MDS_ADR_IRQC: begin
                    next_st.global_irq_enable = wd[MDS_I_GIE];
                    next_st.ext_irq_enable = wd[MDS_I_EIE];
                    next_st.timer_irq_enable = wd[MDS_I_TIE];
                    next_st.ext_irq_flag = wd[MDS_I_EIF];
                    next_st.timer_request_flag = wd[MDS_I_TIF];
                end
                default: mem_we = (ea >= MDS_RAM_LO);
            endcase
        end
        // power-down and time-out flags; time-out set wins
        if (wdt_clear_in) begin
            next_st.powerdown_flag = 1'b0;
            next_st.watchdog_timeout_flag = 1'b0;
        end
        if (halt_in) begin
            next_st.powerdown_flag = 1'b1;
            next_st.watchdog_timeout_flag = 1'b0;
        end
        if (wdt_timeout_in) next_st.watchdog_timeout_flag = 1'b1;
        if (tbl_rd_in) begin
            next_st.tbl_addr = {tbl_last_in ? MDS_LAST_PAGE : pc_in[11:8],
                                st.table_pointer};
        end
        if (tbl_high_we_in) next_st.table_high_byte = tbl_high_in;
        // interrupt service; only the vector goes out, the sequencer
        // pushes the pc and nothing else
        if (ret_irq_in) next_st.global_irq_enable = 1'b1;
        take_ext = irq_slot_in && st.global_irq_enable && !stack_full_in
                   && st.ext_irq_enable && st.ext_irq_flag;
        take_tmr = irq_slot_in && st.global_irq_enable && !stack_full_in
                   && st.timer_irq_enable && st.timer_request_flag
                   && !take_ext;
        if (take_ext || take_tmr) begin
            next_st.global_irq_enable = 1'b0;
            next_st.irq_call = 1'b1;
        end
        if (take_ext) begin
            next_st.ext_irq_flag = 1'b0;
            next_st.irq_vec = MDS_VEC_EXT;
        end
        if (take_tmr) begin
            next_st.timer_request_flag = 1'b0;
            next_st.irq_vec = MDS_VEC_TMR;
        end
        // two-stage synchroniser, edge from stage two and its delay
        next_st.pin_s1 = ext_irq_pin_in;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        ext_edge = edge_select_output_in ?
                   (st.pin_s2 && !st.pin_prev) :
                   (!st.pin_s2 && st.pin_prev);
        // new events override clears in the same cycle
        if (ext_edge) next_st.ext_irq_flag = 1'b1;
        if (timer_ovf_in) next_st.timer_request_flag = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // pin stages reset low: a pin held high through reset can look
    // like a rising edge, so software clears the flag after start-up
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // storage has no reset, it holds its contents across warm restarts
    always_ff @(posedge ref_clk_in) begin
        if (mem_we) ram[ea] <= wd;
    end

    assign rd_data_out    = st.rd_data;
    assign rd_valid_out   = st.rd_valid;
    assign tbl_addr_out   = st.tbl_addr;
    assign irq_call_out   = st.irq_call;
    assign irq_vector_out = st.irq_vec;
    assign pcl_load_out   = st.pcl_load;
    assign pcl_data_out   = st.pcl_data;
    assign skip_out       = st.skip;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);
    property p_tbl_addr;
        tbl_rd_in |=> tbl_addr_out == {$past(tbl_last_in) ? MDS_LAST_PAGE
                      : $past(pc_in[11:8]), $past(st.table_pointer)};
    endproperty
    a_tbl_addr: assert property (p_tbl_addr)
        else $error("table address wrong");
    property p_rsv_read;
        rd_en_in && addr_in > MDS_ADR_IRQC && addr_in < MDS_RAM_LO
        |=> rd_valid_out && rd_data_out == MDS_READ_ZERO;
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("reserved read not zero");
    sequence s_ram_wr;
        wr_en_in && addr_in >= MDS_RAM_LO && !alu_en_in
        && !bit_set_in && !bit_clr_in;
    endsequence
    sequence s_ram_rd;
        rd_en_in && !wr_en_in && addr_in == $past(addr_in);
    endsequence
    property p_ram_rw;
        s_ram_wr ##1 s_ram_rd |=> rd_data_out == $past(wdata_in, 2);
    endproperty
    a_ram_rw: assert property (p_ram_rw)
        else $error("storage read back wrong");
    property p_ind_self;
        rd_en_in && addr_in == MDS_ADR_IND0
        && (st.pointer_zero == MDS_ADR_IND0
            || st.pointer_zero == MDS_ADR_IND1)
        |=> rd_data_out == MDS_READ_ZERO;
    endproperty
    a_ind_self: assert property (p_ind_self)
        else $error("indirect self read not zero");
    property p_halt;
        halt_in && !wdt_clear_in && !wdt_timeout_in
        |=> st.powerdown_flag && !st.watchdog_timeout_flag;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt flags wrong");
    property p_flags_wr;
        wr_en_in && addr_in == MDS_ADR_FLAGS && !alu_en_in && !halt_in
        && !wdt_clear_in && !wdt_timeout_in
        |=> st.powerdown_flag == $past(st.powerdown_flag)
        && st.watchdog_timeout_flag == $past(st.watchdog_timeout_flag)
        && st.carry_flag == $past(wdata_in[MDS_F_C]);
    endproperty
    a_flags_wr: assert property (p_flags_wr)
        else $error("status write touched protected flags");
    property p_take;
        take_ext || take_tmr |=> irq_call_out && !st.global_irq_enable
        && irq_vector_out == ($past(take_ext) ? MDS_VEC_EXT : MDS_VEC_TMR);
    endproperty
    a_take: assert property (p_take)
        else $error("interrupt entry wrong");
    property p_stack_full;
        stack_full_in |=> !irq_call_out;
    endproperty
    a_stack_full: assert property (p_stack_full)
        else $error("interrupt taken with stack full");
    sequence s_pin_rise;
        edge_select_output_in && !ext_irq_pin_in && !st.pin_s2
        ##1 (edge_select_output_in && ext_irq_pin_in) [*3];
    endsequence
    property p_pin_rise;
        s_pin_rise |=> st.ext_irq_flag;
    endproperty
    a_pin_rise: assert property (p_pin_rise)
        else $error("rising pin edge not flagged");
    property p_return_from_irq_instr;
        ret_irq_in && !take_ext && !take_tmr |=> st.global_irq_enable;
    endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr)
        else $error("return did not enable interrupts");
endmodule : mds_core
`default_nettype wire

// File: pkg/mds_pkg.sv
// constants for the data space, status flag and interrupt block
`default_nettype none
package mds_pkg;
    // data space addresses
    localparam logic [7:0] MDS_ADR_IND0  = 8'h00;
    localparam logic [7:0] MDS_ADR_PTR0  = 8'h01;
    localparam logic [7:0] MDS_ADR_IND1  = 8'h02;
    localparam logic [7:0] MDS_ADR_PTR1  = 8'h03;
    localparam logic [7:0] MDS_ADR_ACC   = 8'h05;
    localparam logic [7:0] MDS_ADR_PCL   = 8'h06;
    localparam logic [7:0] MDS_ADR_TABLE_POINTER  = 8'h07;
    localparam logic [7:0] MDS_ADR_TABLE_HIGH_BYTE  = 8'h08;
    localparam logic [7:0] MDS_ADR_FLAGS = 8'h0A;
    localparam logic [7:0] MDS_ADR_IRQC  = 8'h0B;
    localparam logic [7:0] MDS_RAM_LO    = 8'h60;
    localparam int         MDS_RAM_FIRST = 96;
    localparam int         MDS_RAM_LAST  = 255;
    localparam logic [7:0] MDS_READ_ZERO = 8'h00;
    // table page and interrupt vectors
    localparam logic [3:0]  MDS_LAST_PAGE = 4'hB;
    localparam logic [11:0] MDS_VEC_EXT   = 12'h004;
    localparam logic [11:0] MDS_VEC_TMR   = 12'h008;
    // flags_register bits
    localparam int MDS_F_C   = 0;
    localparam int MDS_F_AC  = 1;
    localparam int MDS_F_Z   = 2;
    localparam int MDS_F_OV  = 3;
    localparam int MDS_F_PDF = 4;
    localparam int MDS_F_TO  = 5;
    // irq_control bits
    localparam int MDS_I_GIE = 0;
    localparam int MDS_I_EIE = 1;
    localparam int MDS_I_TIE = 2;
    localparam int MDS_I_EIF = 4;
    localparam int MDS_I_TIF = 5;
    // decimal adjust
    localparam logic [3:0] MDS_BCD_MAX = 4'h9;
    localparam logic [8:0] MDS_ADJ_LO  = 9'h006;
    localparam logic [8:0] MDS_ADJ_HI  = 9'h060;
    // alu operation codes
    localparam logic [3:0] MDS_OP_ADD = 4'h0;
    localparam logic [3:0] MDS_OP_ADC = 4'h1;
    localparam logic [3:0] MDS_OP_SUB = 4'h2;
    localparam logic [3:0] MDS_OP_SBC = 4'h3;
    localparam logic [3:0] MDS_OP_DAA = 4'h4;
    localparam logic [3:0] MDS_OP_AND = 4'h5;
    localparam logic [3:0] MDS_OP_OR  = 4'h6;
    localparam logic [3:0] MDS_OP_XOR = 4'h7;
    localparam logic [3:0] MDS_OP_CPL = 4'h8;
    localparam logic [3:0] MDS_OP_RL  = 4'h9;
    localparam logic [3:0] MDS_OP_RR  = 4'hA;
    localparam logic [3:0] MDS_OP_RLC = 4'hB;
    localparam logic [3:0] MDS_OP_RRC = 4'hC;
    localparam logic [3:0] MDS_OP_INC = 4'hD;
    localparam logic [3:0] MDS_OP_DEC = 4'hE;
endpackage : mds_pkg
`default_nettype wire

// File: test/mds_seq_model.sv
// sequencer model: instruction boundary and six-level return stack
`timescale 1ns/10ps
`default_nettype none
module mds_seq_model (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic slot_en_in,
    input  wire logic fill_in,
    input  wire logic call_in,
    input  wire logic ret_in,
    output logic      irq_slot_out,
    output logic      stack_full_out
);
    logic [2:0] depth;
    // only the return address is pushed, so a depth count is enough
    always_ff @(posedge clk_in) begin
        if (reset_in) depth <= 3'h0;
        else if (fill_in) depth <= 3'h6;
        else if (call_in) depth <= depth + 3'h1;
        else if (ret_in && depth != 3'h0) depth <= depth - 3'h1;
    end
    assign stack_full_out = (depth == 3'h6);
    assign irq_slot_out   = slot_en_in;
endmodule : mds_seq_model
`default_nettype wire

// File: test/test_mcu_data_space_status_and_interrupt.sv
// self-checking bench for the data space, flag and interrupt block
`timescale 1ns/10ps
`default_nettype none
module test_mcu_data_space_status_and_interrupt;
    import mds_pkg::*;
    logic        ref_clk_in = '0, reset_in = 1'h1, rd_en_in = '0;
    logic        wr_en_in = '0, alu_to_acc_in = 1'h1, tbl_last_in = '0;
    logic        tbl_high_we_in = '0, ext_irq_pin_in = '0, fill = '0;
    logic        edge_select_output_in = '0, slot_en = '0;
    logic        stack_full_in, irq_slot_in, rd_valid_out, irq_call_out;
    logic        pcl_load_out, skip_out;
    logic [8:0]  strb = '0;
    logic [2:0]  bit_sel_in = '0;
    logic [3:0]  alu_op_in = '0;
    logic [7:0]  addr_in = '0, wdata_in = '0, alu_operand_in = '0;
    logic [7:0]  tbl_high_in = '0, rd_data_out, pcl_data_out;
    logic [11:0] pc_in = 12'hABC, tbl_addr_out, irq_vector_out;
    logic [11:0] vecs[$];
    int          miscompares = 0, check_count = 0, cycles = 0;
    // single strobe vector keeps one driver per pulse input
    wire halt_in = strb[0], wdt_clear_in = strb[1], wdt_timeout_in = strb[2];
    wire timer_ovf_in = strb[3], tbl_rd_in = strb[4], ret_irq_in = strb[5];
    wire alu_en_in = strb[6], bit_set_in = strb[7], bit_clr_in = strb[8];
    mds_core i_mds_core (.ref_clk_in, .reset_in, .rd_en_in, .wr_en_in,
        .addr_in, .wdata_in, .bit_set_in, .bit_clr_in, .bit_sel_in,
        .alu_en_in, .alu_op_in, .alu_operand_in, .alu_to_acc_in, .tbl_rd_in,
        .tbl_last_in, .pc_in, .tbl_high_we_in, .tbl_high_in, .halt_in,
        .wdt_clear_in, .wdt_timeout_in, .timer_ovf_in, .ext_irq_pin_in,
        .edge_select_output_in, .stack_full_in, .irq_slot_in, .ret_irq_in,
        .rd_data_out, .rd_valid_out, .tbl_addr_out, .irq_call_out,
        .irq_vector_out, .pcl_load_out, .pcl_data_out, .skip_out);
    mds_seq_model i_mds_seq_model (.clk_in(ref_clk_in), .reset_in,
        .slot_en_in(slot_en), .fill_in(fill), .call_in(irq_call_out),
        .ret_in(ret_irq_in), .irq_slot_out(irq_slot_in),
        .stack_full_out(stack_full_in));
    always #10 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (irq_call_out === 1'h1) vecs.push_back(irq_vector_out);
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick
    // strobes drop after one edge, and a spare edge avoids double drives
    task automatic pls(input int b);
        strb[b] <= 1'h1;
        tick(1);
        strb <= '0;
        tick(1);
    endtask : pls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_en_in <= 1'h1;
        tick(1);
        wr_en_in <= 1'h0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        addr_in <= a;
        rd_en_in <= 1'h1;
        tick(1);
        rd_en_in <= 1'h0;
        #1;
        chk({11'h0, rd_valid_out}, 12'h1);
        chk({4'h0, rd_data_out}, {4'h0, d});
        tick(1);
    endtask : rd
    task automatic alu(input logic [3:0] op, input logic [7:0] b);
        alu_op_in <= op;
        alu_operand_in <= b;
        pls(6);
    endtask : alu
    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(16);
        reset_in <= 1'h0;
        tick(2);
        rd(MDS_ADR_FLAGS, 8'h00);
        rd(MDS_ADR_IRQC, 8'h00);
        wr(8'h60, 8'h5A);
        wr(8'hFF, 8'hC3);
        rd(8'hFF, 8'hC3);
        addr_in <= 8'h70;
        wdata_in <= 8'h96;
        wr_en_in <= 1'h1;
        tick(1);
        wr_en_in <= 1'h0;
        rd(8'h70, 8'h96);
        rd(8'h04, 8'h00);
        rd(8'h5F, 8'h00);
        wr(MDS_ADR_PTR0, 8'hFF);
        wr(MDS_ADR_IND0, 8'hA5);
        rd(8'hFF, 8'hA5);
        wr(MDS_ADR_PTR1, 8'h60);
        rd(MDS_ADR_IND1, 8'h5A);
        wr(MDS_ADR_PTR1, MDS_ADR_IND0);
        wr(MDS_ADR_IND1, 8'h11);
        rd(MDS_ADR_IND1, 8'h00);
        wr(MDS_ADR_PTR0, MDS_ADR_IND1);
        rd(MDS_ADR_IND0, 8'h00);
        addr_in <= 8'h60;
        bit_sel_in <= 3'h7;
        pls(7);
        bit_sel_in <= 3'h1;
        pls(8);
        rd(8'h60, 8'hD8);
        $display("memory map test done");
        wr(MDS_ADR_FLAGS, 8'hFF);
        rd(MDS_ADR_FLAGS, 8'h0F);
        pls(0);
        rd(MDS_ADR_FLAGS, 8'h1F);
        pls(2);
        rd(MDS_ADR_FLAGS, 8'h3F);
        pls(0);
        rd(MDS_ADR_FLAGS, 8'h1F);
        wr(MDS_ADR_FLAGS, 8'h00);
        rd(MDS_ADR_FLAGS, 8'h10);
        pls(1);
        rd(MDS_ADR_FLAGS, 8'h00);
        wr(MDS_ADR_ACC, 8'h7F);
        alu(MDS_OP_ADD, 8'h01);
        chk({11'h0, skip_out}, 12'h0);
        rd(MDS_ADR_ACC, 8'h80);
        rd(MDS_ADR_FLAGS, 8'h0A);
        alu(MDS_OP_ADD, 8'h80);
        chk({11'h0, skip_out}, 12'h1);
        rd(MDS_ADR_FLAGS, 8'h0D);
        alu(MDS_OP_SUB, 8'h00);
        rd(MDS_ADR_FLAGS, 8'h07);
        alu(MDS_OP_RLC, 8'h81);
        rd(MDS_ADR_ACC, 8'h03);
        alu(MDS_OP_RRC, 8'h02);
        rd(MDS_ADR_FLAGS, 8'h06);
        wr(MDS_ADR_TABLE_POINTER, 8'h34);
        pls(4);
        chk(tbl_addr_out, 12'hA34);
        tbl_last_in <= 1'h1;
        pls(4);
        chk(tbl_addr_out, 12'hB34);
        tbl_high_in <= 8'h3C;
        tbl_high_we_in <= 1'h1;
        tick(1);
        tbl_high_we_in <= 1'h0;
        wr(MDS_ADR_TABLE_HIGH_BYTE, 8'h00);
        rd(MDS_ADR_TABLE_HIGH_BYTE, 8'h3C);
        wr(MDS_ADR_PCL, 8'h42);
        chk({3'h0, pcl_load_out, pcl_data_out}, 12'h142);
        rd(MDS_ADR_PCL, 8'hBC);
        $display("status and alu test done");
        wr(MDS_ADR_IRQC, 8'h07);
        pls(3);
        edge_select_output_in <= 1'h1;
        fill <= 1'h1;
        tick(2);
        fill <= 1'h0;
        ext_irq_pin_in <= 1'h1;
        tick(6);
        rd(MDS_ADR_IRQC, 8'h37);
        slot_en <= 1'h1;
        tick(4);
        chk(12'(vecs.size()), 12'h0);
        pls(5);
        tick(4);
        slot_en <= 1'h0;
        chk(12'(vecs.size()), 12'h1);
        chk(vecs[0], MDS_VEC_EXT);
        rd(MDS_ADR_IRQC, 8'h26);
        pls(5);
        rd(MDS_ADR_IRQC, 8'h27);
        slot_en <= 1'h1;
        tick(4);
        slot_en <= 1'h0;
        chk(12'(vecs.size()), 12'h2);
        chk(vecs[1], MDS_VEC_TMR);
        rd(MDS_ADR_IRQC, 8'h06);
        edge_select_output_in <= 1'h0;
        ext_irq_pin_in <= 1'h0;
        tick(6);
        rd(MDS_ADR_IRQC, 8'h16);
        $display("interrupt test done");
        conclude();
    end
endmodule : test_mcu_data_space_status_and_interrupt
`default_nettype wire
